// file: core/abo_conv_if.sv
// handshake between the unit and its decimal converter
`include "abo_params.svh"
interface abo_conv_if;
  logic                    start;
  logic                    to_bcd;
  logic [`ABO_ACC_W-1:0]   operand;
  logic                    done;
  logic [`ABO_ACC_W-1:0]   result;
  modport ctl (output start, output to_bcd, output operand, input done, input result);
  modport cvt (input start, input to_bcd, input operand, output done, output result);
endinterface : abo_conv_if

// file: core/abo_dec_conv.sv
// serial packed-decimal and binary converter, one bit per clock
`include "abo_params.svh"
module abo_dec_conv
  import abo_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // converter side
  abo_conv_if.cvt  cv
);
  // ----------------------------------------
  // converter state
  // ----------------------------------------
  logic [`ABO_ACC_W-1:0] bin_reg, bin_next;
  logic [`ABO_ACC_W-1:0] bcd_reg, bcd_next;
  logic [5:0]            step_reg, step_next;
  logic                  busy_reg, busy_next;
  logic                  mode_reg, mode_next;
  logic                  done_reg, done_next;
  logic [`ABO_ACC_W-1:0] tmp;

  // double dabble toward decimal, reverse dabble toward binary
  always_comb begin
    tmp       = '0;
    bin_next  = bin_reg;
    bcd_next  = bcd_reg;
    step_next = step_reg;
    busy_next = busy_reg;
    mode_next = mode_reg;
    done_next = 1'b0;
    if (cv.start && !busy_reg) begin
      busy_next = 1'b1;
      mode_next = cv.to_bcd;
      step_next = '0;
      bin_next  = cv.to_bcd ? cv.operand : '0;
      bcd_next  = cv.to_bcd ? '0 : cv.operand;
    end else if (busy_reg) begin
      if (mode_reg) begin
        tmp = bcd_reg;
        for (int d = 0; d < `ABO_BCD_DIGITS; d++) begin
          if (tmp[d*4 +: 4] > 4'h4) tmp[d*4 +: 4] = tmp[d*4 +: 4] + 4'h3;
        end
        bcd_next = {tmp[`ABO_ACC_W-2:0], bin_reg[`ABO_ACC_W-1]};
        bin_next = {bin_reg[`ABO_ACC_W-2:0], 1'b0};
      end else begin
        bin_next = {bcd_reg[0], bin_reg[`ABO_ACC_W-1:1]};
        tmp      = {1'b0, bcd_reg[`ABO_ACC_W-1:1]};
        for (int d = 0; d < `ABO_BCD_DIGITS; d++) begin
          if (tmp[d*4 +: 4] > 4'h7) tmp[d*4 +: 4] = tmp[d*4 +: 4] - 4'h3;
        end
        bcd_next = tmp;
      end
      step_next = step_reg + 6'd1;
      if (step_reg == 6'(`ABO_BCD_STEPS - 1)) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bin_reg  <= '0;
      bcd_reg  <= '0;
      step_reg <= '0;
      busy_reg <= 1'b0;
      mode_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      bin_reg  <= bin_next;
      bcd_reg  <= bcd_next;
      step_reg <= step_next;
      busy_reg <= busy_next;
      mode_reg <= mode_next;
      done_reg <= done_next;
    end
  end

  assign cv.done   = done_reg;
  assign cv.result = mode_reg ? bcd_reg : bin_reg;
endmodule : abo_dec_conv

// file: core/abo_params.svh
// constants for the accumulator bit operation unit
`ifndef ABO_PARAMS_SVH
`define ABO_PARAMS_SVH
`define ABO_ACC_W       32
`define ABO_CNT_W       6
`define ABO_IDX_W       5
`define ABO_ACC_RESET   32'h0000_0000
`define ABO_BCD_DIGITS  8
`define ABO_BCD_STEPS   32
`endif

// file: core/abo_pkg.sv
// types for the accumulator bit operation unit
`include "abo_params.svh"
package abo_pkg;
  typedef enum logic [3:0] {
    ABO_OP_NONE,
    ABO_OP_LOAD,
    ABO_OP_ROTATE_TOWARD_MSB,
    ABO_OP_ROTATE_TOWARD_LSB,
    ABO_OP_BIT_INDEX_ENCODE,
    ABO_OP_INDEX_TO_ONEHOT,
    ABO_OP_DECIMAL_TO_BINARY_CONVERT,
    ABO_OP_BINARY_TO_DECIMAL_CONVERT,
    ABO_OP_ONES_COMPLEMENT_OP
  } abo_op_t;
  typedef enum logic [1:0] {
    ABO_ST_IDLE,
    ABO_ST_TO_BIN,
    ABO_ST_TO_BCD
  } abo_state_t;
endpackage : abo_pkg

// file: core/abo_unit.sv
// accumulator bit operation unit top
`include "abo_params.svh"
module abo_unit
  import abo_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // command from the sequencer
  input  wire logic                  op_valid,
  input  wire abo_op_t               op_code,
  input  wire logic [`ABO_CNT_W-1:0] op_count,
  input  wire logic [`ABO_ACC_W-1:0] op_load_data,
  // results
  output logic                       op_busy,
  output logic                       op_done,
  output logic [`ABO_ACC_W-1:0]      acc,
  output logic                       operand_overflow_flag
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  abo_state_t            state_reg, state_next;
  logic [`ABO_ACC_W-1:0] acc_reg, acc_next;
  logic                  ovf_reg, ovf_next;
  logic                  busy_reg, busy_next;
  logic                  done_reg, done_next;
  logic [`ABO_IDX_W-1:0] amt;
  logic [`ABO_IDX_W-1:0] low_idx;
  logic                  found;
  logic                  multi;

  abo_conv_if cv ();
  abo_dec_conv u_conv (.core_clk(core_clk), .rst_b(rst_b), .cv(cv));

  // a count of 32 rotates fully round, so only the low five bits matter
  // count of 1 to 32 accepted
  assign amt = op_count[`ABO_IDX_W-1:0];

  // lowest set bit search for encode
  always_comb begin
    low_idx = '0;
    found   = 1'b0;
    multi   = 1'b0;
    for (int i = 0; i < `ABO_ACC_W; i++) begin
      if (acc_reg[i]) begin
        if (found) multi = 1'b1;
        else begin
          low_idx = 5'(i);
          found   = 1'b1;
        end
      end
    end
  end

  // next accumulator, flag and sequencing
  always_comb begin
    state_next = state_reg;
    acc_next   = acc_reg;
    ovf_next   = ovf_reg;
    busy_next  = busy_reg;
    done_next  = 1'b0;
    cv.start   = 1'b0;
    cv.to_bcd  = 1'b0;
    cv.operand = acc_reg;
    case (state_reg)
      ABO_ST_IDLE: begin
        if (op_valid) begin
          done_next = 1'b1;
          case (op_code)
            ABO_OP_LOAD: acc_next = op_load_data;
            // bits leaving msb re-enter at lsb
            ABO_OP_ROTATE_TOWARD_MSB:
              acc_next = (acc_reg << amt) | (acc_reg >> (6'd32 - {1'b0, amt}));
            // bits leaving lsb re-enter at msb
            ABO_OP_ROTATE_TOWARD_LSB:
              acc_next = (acc_reg >> amt) | (acc_reg << (6'd32 - {1'b0, amt}));
            ABO_OP_BIT_INDEX_ENCODE: begin
              // five bit index in low bits
              acc_next = {27'h000_0000, low_idx};
              ovf_next = multi;
            end
            // low five bits give index modulo 32
            ABO_OP_INDEX_TO_ONEHOT:
              acc_next = 32'h0000_0001 << acc_reg[`ABO_IDX_W-1:0];
            ABO_OP_ONES_COMPLEMENT_OP: acc_next = ~acc_reg;
            ABO_OP_DECIMAL_TO_BINARY_CONVERT: begin
              cv.start   = 1'b1;
              done_next  = 1'b0;
              busy_next  = 1'b1;
              state_next = ABO_ST_TO_BIN;
            end
            ABO_OP_BINARY_TO_DECIMAL_CONVERT: begin
              cv.start   = 1'b1;
              cv.to_bcd  = 1'b1;
              done_next  = 1'b0;
              busy_next  = 1'b1;
              state_next = ABO_ST_TO_BCD;
            end
            default: done_next = 1'b1;
          endcase
        end
      end
      ABO_ST_TO_BIN, ABO_ST_TO_BCD: begin
        if (cv.done) begin
          acc_next   = cv.result;
          busy_next  = 1'b0;
          done_next  = 1'b1;
          state_next = ABO_ST_IDLE;
        end
      end
      default: state_next = ABO_ST_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ABO_ST_IDLE;
      acc_reg   <= `ABO_ACC_RESET;
      ovf_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
      ovf_reg   <= ovf_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
    end
  end

  assign acc                   = acc_reg;
  assign operand_overflow_flag = ovf_reg;
  assign op_busy               = busy_reg;
  assign op_done               = done_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_rot_msb;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && op_code == ABO_OP_ROTATE_TOWARD_MSB && amt == 5'd1)
      |=> acc_reg == {$past(acc_reg[30:0]), $past(acc_reg[31])};
  endproperty
  a_rot_msb: assert property (p_rot_msb) else $error("rotate msb wrong");
  property p_rot_lsb;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && op_code == ABO_OP_ROTATE_TOWARD_LSB && amt == 5'd1)
      |=> acc_reg == {$past(acc_reg[0]), $past(acc_reg[31:1])};
  endproperty
  a_rot_lsb: assert property (p_rot_lsb) else $error("rotate lsb wrong");
  property p_rot_keep;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && (op_code == ABO_OP_ROTATE_TOWARD_MSB
      || op_code == ABO_OP_ROTATE_TOWARD_LSB)) |=> $countones(acc_reg) == $countones($past(acc_reg));
  endproperty
  a_rot_keep: assert property (p_rot_keep) else $error("rotate lost bits");
  property p_enc_top;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && op_code == ABO_OP_BIT_INDEX_ENCODE && acc_reg == 32'h8000_0000)
      |=> acc_reg == 32'h0000_001F && !ovf_reg;
  endproperty
  a_enc_top: assert property (p_enc_top) else $error("encode bit31 wrong");
  property p_enc_zero;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && op_code == ABO_OP_BIT_INDEX_ENCODE && acc_reg[31:1] == '0)
      |=> acc_reg == '0;
  endproperty
  a_enc_zero: assert property (p_enc_zero) else $error("encode zero wrong");
  property p_enc_multi;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && op_code == ABO_OP_BIT_INDEX_ENCODE && $countones(acc_reg) > 1)
      |=> ovf_reg && acc_reg[31:5] == '0;
  endproperty
  a_enc_multi: assert property (p_enc_multi) else $error("encode multi wrong");
  property p_flag_hold;
    @(posedge core_clk) disable iff (!rst_b)
    !(op_valid && !busy_reg && op_code == ABO_OP_BIT_INDEX_ENCODE) |=> $stable(ovf_reg);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag changed");
  property p_dec;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && op_code == ABO_OP_INDEX_TO_ONEHOT)
      |=> acc_reg == (32'h0000_0001 << $past(acc_reg[4:0]));
  endproperty
  a_dec: assert property (p_dec) else $error("decode wrong");
  property p_inv;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && op_code == ABO_OP_ONES_COMPLEMENT_OP) |=> acc_reg == ~$past(acc_reg);
  endproperty
  a_inv: assert property (p_inv) else $error("invert wrong");
  property p_conv_end;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && (op_code == ABO_OP_DECIMAL_TO_BINARY_CONVERT
      || op_code == ABO_OP_BINARY_TO_DECIMAL_CONVERT)) |=> op_busy ##[1:34] op_done;
  endproperty
  a_conv_end: assert property (p_conv_end) else $error("convert hung");
  property p_bcd_9;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && op_code == ABO_OP_BINARY_TO_DECIMAL_CONVERT && acc_reg == 32'h0000_0063)
      |=> ##33 acc_reg == 32'h0000_0099;
  endproperty
  a_bcd_9: assert property (p_bcd_9) else $error("bcd wrong");
  // result shapes of decode and encode, and refusal while converting
  property p_dec_one;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && op_code == ABO_OP_INDEX_TO_ONEHOT) |=> $onehot(acc_reg);
  endproperty
  a_dec_one: assert property (p_dec_one) else $error("decode not one-hot");
  property p_enc_low;
    @(posedge core_clk) disable iff (!rst_b)
    (op_valid && !busy_reg && op_code == ABO_OP_BIT_INDEX_ENCODE) |=> acc_reg[31:5] == '0;
  endproperty
  a_enc_low: assert property (p_enc_low) else $error("encode high bits set");
  property p_busy_drop;
    @(posedge core_clk) disable iff (!rst_b)
    (busy_reg && $past(busy_reg)) |-> $stable(acc_reg) && !op_done;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("command taken while busy");
  c_multi: cover property (@(posedge core_clk) ovf_reg);
  c_conv: cover property (@(posedge core_clk) state_reg == ABO_ST_TO_BCD && cv.done);
  c_rot32: cover property (@(posedge core_clk) op_valid && amt == 5'd0);
endmodule : abo_unit

// file: verification/abo_seq_model.sv
// sequencer model that issues commands to the bit operation unit
`include "abo_params.svh"
module abo_seq_model
  import abo_pkg::*;
(
  // clock
  input  wire logic              core_clk,
  // command out
  output logic                   op_valid,
  output abo_op_t                op_code,
  output logic [`ABO_CNT_W-1:0]  op_count,
  output logic [`ABO_ACC_W-1:0]  op_load_data,
  // completion in
  input  wire logic              op_done
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle command lines from time zero
  initial begin
    op_valid     = 1'b0;
    op_code      = ABO_OP_NONE;
    op_count     = 6'h01;
    op_load_data = 32'h0000_0000;
  end

  // one-cycle strobe, returns at the take edge
  task automatic send(input abo_op_t op, input int cnt, input logic [`ABO_ACC_W-1:0] d);
    @(posedge core_clk);
    op_valid     <= 1'b1;
    op_code      <= op;
    op_count     <= (cnt < 1 || cnt > 32) ? 6'h01 : 6'(cnt);
    op_load_data <= d;
    @(posedge core_clk);
    op_valid     <= 1'b0;
    // released data must not look held
    op_load_data <= ~d;
  endtask : send

  // cycles from take edge to done, bounded so a hang cannot stall us;
  // the first negedge after the take edge already counts as one cycle
  task automatic await(output int n);
    n = 0;
    while (n < 40 && op_done !== 1'b1) begin
      @(negedge core_clk);
      n++;
    end
  endtask : await
endmodule : abo_seq_model

// file: verification/test_abo_unit.sv
// self-checking bench for the accumulator bit operation unit
`include "abo_params.svh"
module test_abo_unit
  import abo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  core_clk;
  logic                  rst_b;
  logic                  op_valid;
  abo_op_t               op_code;
  logic [`ABO_CNT_W-1:0] op_count;
  logic [`ABO_ACC_W-1:0] op_load_data;
  logic                  op_busy;
  logic                  op_done;
  logic [`ABO_ACC_W-1:0] acc;
  logic                  operand_overflow_flag;
  int                    fail_count;
  int                    n_tests;
  int                    cycles;

  abo_unit i_abo_unit (.core_clk(core_clk), .rst_b(rst_b), .op_valid(op_valid),
    .op_code(op_code), .op_count(op_count), .op_load_data(op_load_data), .op_busy(op_busy),
    .op_done(op_done), .acc(acc), .operand_overflow_flag(operand_overflow_flag));

  abo_seq_model i_abo_seq_model (.core_clk(core_clk), .op_valid(op_valid),
    .op_code(op_code), .op_count(op_count), .op_load_data(op_load_data), .op_done(op_done));

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // ceiling well above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic run(input abo_op_t op, input int c, input logic [31:0] d, output int n);
    i_abo_seq_model.send(op, c, d);
    i_abo_seq_model.await(n);
  endtask : run

  task automatic ld(input logic [31:0] d);
    int n;
    run(ABO_OP_LOAD, 1, d, n);
  endtask : ld

  function automatic logic [31:0] rot(input logic [31:0] v, input int r);
    return (r == 0) ? v : ((v << r) | (v >> (32 - r)));
  endfunction : rot

  // load, apply one single-cycle op, judge result, flag and latency
  task automatic op1(input string what, input abo_op_t op, input logic [31:0] d,
                     input logic [31:0] e, input logic f);
    int n;
    ld(d);
    run(op, 1, 32'h0000_0000, n);
    chk(what, e, acc);
    chk({what, " flag"}, 32'(f), 32'(operand_overflow_flag));
    chk({what, " cycles"}, 32'h0000_0001, 32'(n));
  endtask : op1

  task automatic t_rotate();
    int c[4];
    int n;
    c = '{1, 2, 31, 32};
    foreach (c[i]) begin
      ld(32'h8421_0F0F);
      run(ABO_OP_ROTATE_TOWARD_MSB, c[i], 32'h0000_0000, n);
      chk("rot msb", rot(32'h8421_0F0F, c[i] % 32), acc);
      ld(32'h8421_0F0F);
      run(ABO_OP_ROTATE_TOWARD_LSB, c[i], 32'h0000_0000, n);
      chk("rot lsb", rot(32'h8421_0F0F, (32 - c[i]) % 32), acc);
    end
  endtask : t_rotate

  task automatic t_bits();
    op1("enc zero", ABO_OP_BIT_INDEX_ENCODE, 32'h0000_0000, 32'h0000_0000, 1'b0);
    op1("enc bit0", ABO_OP_BIT_INDEX_ENCODE, 32'h0000_0001, 32'h0000_0000, 1'b0);
    op1("enc bit31", ABO_OP_BIT_INDEX_ENCODE, 32'h8000_0000, 32'h0000_001F, 1'b0);
    op1("enc multi", ABO_OP_BIT_INDEX_ENCODE, 32'h8001_0100, 32'h0000_0008, 1'b1);
    op1("dec 15", ABO_OP_INDEX_TO_ONEHOT, 32'h0000_000F, 32'h0000_8000, 1'b1);
    op1("dec 47", ABO_OP_INDEX_TO_ONEHOT, 32'h0000_002F, 32'h0000_8000, 1'b1);
    op1("dec 31", ABO_OP_INDEX_TO_ONEHOT, 32'h0000_001F, 32'h8000_0000, 1'b1);
    op1("enc one", ABO_OP_BIT_INDEX_ENCODE, 32'h0000_0400, 32'h0000_000A, 1'b0);
    op1("invert", ABO_OP_ONES_COMPLEMENT_OP, 32'hA5A5_0F0F, 32'h5A5A_F0F0, 1'b0);
  endtask : t_bits

  task automatic t_convert();
    int n;
    ld(32'h1234_5678);
    run(ABO_OP_DECIMAL_TO_BINARY_CONVERT, 1, 32'h0000_0000, n);
    chk("to binary", 32'h00BC_614E, acc);
    chk("to binary cycles", 32'h0000_0022, 32'(n));
    ld(32'h05F5_E0FF);
    run(ABO_OP_BINARY_TO_DECIMAL_CONVERT, 1, 32'h0000_0000, n);
    chk("to decimal", 32'h9999_9999, acc);
    chk("to decimal cycles", 32'h0000_0022, 32'(n));
    // an invert sent while busy must be dropped
    ld(32'h0000_0099);
    i_abo_seq_model.send(ABO_OP_DECIMAL_TO_BINARY_CONVERT, 1, 32'h0000_0000);
    i_abo_seq_model.send(ABO_OP_ONES_COMPLEMENT_OP, 1, 32'h0000_0000);
    // look at busy once it has settled, away from the launching edge
    @(negedge core_clk);
    chk("busy", 32'h0000_0001, 32'(op_busy));
    i_abo_seq_model.await(n);
    chk("busy refusal", 32'h0000_0063, acc);
    // two-digit value back to packed decimal
    run(ABO_OP_BINARY_TO_DECIMAL_CONVERT, 1, 32'h0000_0000, n);
    chk("back to decimal", 32'h0000_0099, acc);
  endtask : t_convert

  // reset, then the scenarios in turn
  initial begin
    fail_count = 0;
    n_tests    = 0;
    cycles     = 0;
    rst_b      = 1'b0;
    repeat (6) @(posedge core_clk);
    chk("reset acc", 32'h0000_0000, acc);
    chk("reset flag", 32'h0000_0000, 32'(operand_overflow_flag));
    rst_b <= 1'b1;
    t_rotate();
    t_bits();
    t_convert();
    summarize();
  end
endmodule : test_abo_unit
